/* logic/timer2_pkg.sv */
// Shared constants for the 16-bit capture/reload timer with baud and clock-out.
// Assumes a single system clock; no bus, all control bits arrive as ports.
package timer2_pkg;

    // Counter geometry
    localparam int          COUNT_W       = 16;
    localparam int          BYTE_W        = 8;
    localparam logic [15:0] COUNT_ONES    = 16'hFFFF;
    localparam logic [15:0] COUNT_ZERO    = 16'h0000;
    localparam logic [15:0] COUNT_RST     = 16'h0000;
    localparam logic [15:0] RELOAD_RST    = 16'h0000;

    // Byte positions inside the 16-bit count
    localparam int          HI_MSB        = 15;
    localparam int          HI_LSB        = 8;
    localparam int          LO_MSB        = 7;
    localparam int          LO_LSB        = 0;

    // Rate dividers of the system clock
    localparam int          DIV_SLOW      = 12;
    localparam int          DIV_HALF      = 2;
    localparam int          PRESC_W       = 4;

    // Reset levels of flags and pins
    localparam logic        FLAG_RST      = 1'b0;
    localparam logic        PIN_RST       = 1'b0;
    localparam logic        SYNC_RST      = 1'b1;

    // Operating mode of the counter
    typedef enum logic [1:0] {
        MODE_CAPTURE,
        MODE_RELOAD_UP,
        MODE_UPDOWN,
        MODE_BAUD
    } mode_e;

endpackage

/* logic/pin_sync.sv */
// Three-flop pin synchroniser with agreement filter and falling-edge pulse.
// Assumes the pin is asynchronous to ref_clk; idles high after reset.
`timescale 1ns/1ns
`default_nettype none
module pin_sync
    import timer2_pkg::*;
(
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Pin side
    input  wire logic pinIn,
    // Synchronous side
    output logic      level,
    output logic      fall
);

    logic stage1_reg;
    logic stage2_reg;
    logic stage3_reg;
    logic level_reg;
    logic fall_reg;

    // Level only moves once the last two stages agree
    wire agree     = (stage2_reg == stage3_reg);
    wire levelNext = agree ? stage3_reg : level_reg;
    wire fallNext  = level_reg & ~levelNext;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            stage1_reg <= SYNC_RST;
            stage2_reg <= SYNC_RST;
            stage3_reg <= SYNC_RST;
            level_reg  <= SYNC_RST;
            fall_reg   <= 1'b0;
        end else begin
            stage1_reg <= pinIn;
            stage2_reg <= stage1_reg;
            stage3_reg <= stage2_reg;
            level_reg  <= levelNext;
            fall_reg   <= fallNext;
        end
    end

    assign level = level_reg;
    assign fall  = fall_reg;

    AST_FALL_FROM_HIGH: assert property (@(posedge ref_clk) disable iff (!arst_n)
        fall |-> $past(level) && !level)
        else $error("Falling pulse without a high then low sample");

endmodule
`default_nettype wire

/* logic/clk_prescaler.sv */
// Enable-pulse prescaler: one pulse every SLOW_DIV and every HALF_DIV clocks.
// Assumes ref_clk is the system clock; runs freely from reset.
`timescale 1ns/1ns
`default_nettype none
module clk_prescaler
    import timer2_pkg::*;
#(
    parameter int SLOW_DIV = DIV_SLOW,
    parameter int HALF_DIV = DIV_HALF
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Enable pulses
    output logic      tickSlow,
    output logic      tickHalf
);

    if (SLOW_DIV < 2 || SLOW_DIV > (1 << PRESC_W) || HALF_DIV != 2) begin : gBadDiv
        $error("clk_prescaler: unsupported divider");
    end

    localparam logic [PRESC_W-1:0] SLOW_LAST = PRESC_W'(SLOW_DIV - 1);

    logic [PRESC_W-1:0] slowCnt_reg;
    logic               halfPh_reg;
    logic               tickSlow_reg;
    logic               tickHalf_reg;

    wire                slowWrap    = (slowCnt_reg == SLOW_LAST);
    wire [PRESC_W-1:0]  slowCntNext = slowWrap ? '0 : slowCnt_reg + 1'b1;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            slowCnt_reg  <= '0;
            halfPh_reg   <= 1'b0;
            tickSlow_reg <= 1'b0;
            tickHalf_reg <= 1'b0;
        end else begin
            slowCnt_reg  <= slowCntNext;
            halfPh_reg   <= ~halfPh_reg;
            tickSlow_reg <= slowWrap;
            tickHalf_reg <= halfPh_reg;
        end
    end

    assign tickSlow = tickSlow_reg;
    assign tickHalf = tickHalf_reg;

    AST_HALF_ALTERNATES: assert property (@(posedge ref_clk) disable iff (!arst_n)
        tickHalf |=> !tickHalf ##1 tickHalf)
        else $error("Half-rate tick is not every second cycle");

endmodule
`default_nettype wire

/* logic/timer2_core.sv */
// 16-bit timer/counter: capture, auto-reload up or up/down, baud, clock-out.
// Assumes software drives the control bits and byte writes as same-clock ports.
//
// Overview of operation
// - 16-bit counter is an internal timer or an external event counter by select bit.
// - Capture mode without trigger enable: plain counter, overflow sets overflow flag.
// - Capture mode with trigger enable: trigger falling edge copies count to capture bytes.
// - That capture also sets external flag, which shares the timer interrupt.
// - Up-only reload mode: overflow past all ones sets flag and loads reload value.
// - Up-only reload mode with enable: trigger falling edge reloads and sets external flag.
// - Up-only reload mode: interrupt asserted when enabled and either flag is one.
// - Up/down mode, trigger high: count up, overflow sets flag and reloads.
// - Up/down mode, trigger low: count down, match with reload sets flag, loads ones.
// - Up/down mode: external flag toggles on each wrap and raises no interrupt.
// - Clock select bits route timer 1 or this timer overflow to transmitter/receiver.
// - Baud mode: high byte rollover reloads, sets no flag, raises no interrupt.
// - Baud mode with enable: trigger falling edge sets external flag only.
// - Baud mode counts at half system clock or from the count pin.
// - Clock-out enabled and reload selected: 50% square wave driven on the pin.
// - Clock-out mode: count at half system clock, reload on each overflow.
// - Clock-out mode: overflows never set overflow flag nor interrupt.
// - Baud generation and clock-out may run together from one overflow rate.
// - Timer operation counts system clock divided by twelve or undivided.
// - Either clock select bit forces auto-reload, ignoring capture select.
// - Overflow flag is cleared by software only; external flag by software or an up/down wrap toggle.
// - Counter operation counts falling edges of the count pin.
`timescale 1ns/1ns
`default_nettype none
module timer2_core
    import timer2_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        arst_n,
    // Control bits
    input  wire logic        run_bit,
    input  wire logic        cnt_sel,
    input  wire logic        cap_rel_sel,
    input  wire logic        ext_trig_en,
    input  wire logic        down_cnt_en,
    input  wire logic        clkout_en,
    input  wire logic        clk_rate_sel,
    input  wire logic        tx_clk_sel,
    input  wire logic        rx_clk_sel,
    input  wire logic        irqEn,
    // Software byte writes and flag clears
    input  wire logic [7:0]  wrData,
    input  wire logic        wrCountHi,
    input  wire logic        wrCountLo,
    input  wire logic        wrReloadHi,
    input  wire logic        wrReloadLo,
    input  wire logic        clrOvfFlag,
    input  wire logic        clrExtFlag,
    // Pins
    input  wire logic        count_pin,
    input  wire logic        trigger_pin,
    output logic             clkoutPinOut,
    output logic             clkoutPinOe,
    // Serial port baud side
    input  wire logic        timer1Ovf,
    output logic             txBaudTick,
    output logic             rxBaudTick,
    // Status
    output logic [7:0]       count_hi,
    output logic [7:0]       count_lo,
    output logic [7:0]       cap_reload_hi,
    output logic [7:0]       cap_reload_lo,
    output logic             ovf_flag,
    output logic             ext_flag,
    output logic             timerIrq
);

    ////////////////////////////////////////////////////////////////////////////
    // Pin conditioning and rate ticks

    logic countLevel;
    logic countFall;
    logic trigLevel;
    logic trigFall;
    logic tickSlow;
    logic tickHalf;

    pin_sync uCountSync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pinIn   (count_pin),
        .level   (countLevel),
        .fall    (countFall)
    );

    pin_sync uTrigSync (
        .ref_clk (ref_clk),
        .arst_n  (arst_n),
        .pinIn   (trigger_pin),
        .level   (trigLevel),
        .fall    (trigFall)
    );

    clk_prescaler #(
        .SLOW_DIV (DIV_SLOW),
        .HALF_DIV (DIV_HALF)
    ) uPresc (
        .ref_clk  (ref_clk),
        .arst_n   (arst_n),
        .tickSlow (tickSlow),
        .tickHalf (tickHalf)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Registers

    logic [15:0] count_reg;
    logic [15:0] reload_reg;
    logic        ovfFlag_reg;
    logic        extFlag_reg;
    logic        irq_reg;
    logic        txTick_reg;
    logic        rxTick_reg;
    logic        clkPin_reg;
    logic        clkOe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Mode decode

    wire   baudSel     = tx_clk_sel | rx_clk_sel;
    wire   clkoutMode  = clkout_en & ~cap_rel_sel;
    mode_e mode;

    assign mode = baudSel     ? MODE_BAUD      :
                  cap_rel_sel ? MODE_CAPTURE   :
                  down_cnt_en ? MODE_UPDOWN    : MODE_RELOAD_UP;

    wire isCapture = (mode == MODE_CAPTURE);
    wire isUpDown  = (mode == MODE_UPDOWN);
    wire isBaud    = (mode == MODE_BAUD);

    ////////////////////////////////////////////////////////////////////////////
    // Count source

    // Baud and clock-out both run from the half-rate tick so they share one rate
    wire halfRate  = isBaud | clkoutMode;
    wire timerTick = halfRate ? tickHalf : (clk_rate_sel | tickSlow);
    wire srcTick   = cnt_sel ? countFall : timerTick;
    wire step      = run_bit & srcTick;

    // Direction only matters in up/down mode; otherwise always up
    wire countUp   = ~isUpDown | trigLevel;
    wire atOnes    = (count_reg == COUNT_ONES);
    wire atReload  = (count_reg == reload_reg);
    wire wrapEvt   = step & (countUp ? atOnes : atReload);

    // Trigger events act regardless of the run bit
    wire trigEvt   = ext_trig_en & trigFall;
    wire capEvt    = trigEvt & isCapture;
    wire trigLoad  = trigEvt & (mode == MODE_RELOAD_UP);

    ////////////////////////////////////////////////////////////////////////////
    // Count next value

    wire [15:0] countWr   = {wrCountHi ? wrData : count_reg[HI_MSB:HI_LSB],
                             wrCountLo ? wrData : count_reg[LO_MSB:LO_LSB]};
    wire        countWrEn = wrCountHi | wrCountLo;

    wire [15:0] wrapVal   = isCapture ? COUNT_ZERO :
                            countUp   ? reload_reg :
                                        COUNT_ONES;
    wire [15:0] stepVal   = countUp ? count_reg + 16'h0001 : count_reg - 16'h0001;

    wire [15:0] countNext = countWrEn ? countWr    :
                            trigLoad  ? reload_reg :
                            wrapEvt   ? wrapVal    :
                            step      ? stepVal    : count_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Capture/reload next value

    wire [15:0] reloadWr   = {wrReloadHi ? wrData : reload_reg[HI_MSB:HI_LSB],
                              wrReloadLo ? wrData : reload_reg[LO_MSB:LO_LSB]};
    wire        reloadWrEn = wrReloadHi | wrReloadLo;
    wire [15:0] reloadNext = reloadWrEn ? reloadWr  :
                             capEvt     ? count_reg : reload_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Flags and interrupt

    // Baud and clock-out wraps never raise the overflow flag
    wire ovfSet   = wrapEvt & ~isBaud & ~clkoutMode;
    wire ovfNext  = ovfSet | (ovfFlag_reg & ~clrOvfFlag);

    // Set wins over clear; in up/down the wrap toggle wins over clear
    wire extSet   = trigEvt & ~isUpDown;
    wire extHeld  = extFlag_reg & ~clrExtFlag;
    wire extNext  = isUpDown ? (wrapEvt ? ~extFlag_reg : extHeld)
                             : (extSet | extHeld);

    wire irqNext  = irqEn & (ovfFlag_reg | (extFlag_reg & ~isUpDown));

    ////////////////////////////////////////////////////////////////////////////
    // Baud ticks and clock-out pin

    wire txNext     = tx_clk_sel ? wrapEvt : timer1Ovf;
    wire rxNext     = rx_clk_sel ? wrapEvt : timer1Ovf;
    // Toggling per wrap gives an exact 50% duty cycle
    wire clkPinNext = clkoutMode & (wrapEvt ? ~clkPin_reg : clkPin_reg);

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            count_reg   <= COUNT_RST;
            reload_reg  <= RELOAD_RST;
            ovfFlag_reg <= FLAG_RST;
            extFlag_reg <= FLAG_RST;
            irq_reg     <= 1'b0;
            txTick_reg  <= 1'b0;
            rxTick_reg  <= 1'b0;
            clkPin_reg  <= PIN_RST;
            clkOe_reg   <= 1'b0;
        end else begin
            count_reg   <= countNext;
            reload_reg  <= reloadNext;
            ovfFlag_reg <= ovfNext;
            extFlag_reg <= extNext;
            irq_reg     <= irqNext;
            txTick_reg  <= txNext;
            rxTick_reg  <= rxNext;
            clkPin_reg  <= clkPinNext;
            clkOe_reg   <= clkoutMode;
        end
    end

    assign count_hi      = count_reg[HI_MSB:HI_LSB];
    assign count_lo      = count_reg[LO_MSB:LO_LSB];
    assign cap_reload_hi = reload_reg[HI_MSB:HI_LSB];
    assign cap_reload_lo = reload_reg[LO_MSB:LO_LSB];
    assign ovf_flag      = ovfFlag_reg;
    assign ext_flag      = extFlag_reg;
    assign timerIrq      = irq_reg;
    assign txBaudTick    = txTick_reg;
    assign rxBaudTick    = rxTick_reg;
    assign clkoutPinOut  = clkPin_reg;
    assign clkoutPinOe   = clkOe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    wire quiet = ~countWrEn & ~reloadWrEn & ~trigLoad;

    AST_CAPTURE_WRAP: assert property (
        isCapture && wrapEvt && quiet |=> count_reg == COUNT_ZERO && ovfFlag_reg)
        else $error("Capture-mode overflow did not wrap to zero with flag");

    AST_CAPTURE_COPY: assert property (
        capEvt && !reloadWrEn |=> reload_reg == $past(count_reg))
        else $error("Trigger edge did not capture the count");

    AST_EXT_ON_TRIGGER: assert property (
        trigEvt && !isUpDown |=> extFlag_reg)
        else $error("Trigger edge did not set external flag");

    AST_RELOAD_UP: assert property (
        mode == MODE_RELOAD_UP && wrapEvt && quiet
        |=> count_reg == $past(reload_reg)
            && (ovfFlag_reg == !$past(clkoutMode) || $past(ovfFlag_reg)))
        else $error("Up-count overflow did not reload");

    AST_DOWN_MATCH: assert property (
        isUpDown && wrapEvt && !countUp && quiet |=> count_reg == COUNT_ONES)
        else $error("Down-count match did not load all ones");

    AST_UPDOWN_TOGGLE: assert property (
        isUpDown && wrapEvt |=> extFlag_reg != $past(extFlag_reg))
        else $error("External flag did not toggle on up/down wrap");

    AST_BAUD_NO_FLAG: assert property (
        isBaud && !ovfFlag_reg |=> !ovfFlag_reg)
        else $error("Overflow flag set in baud mode");

    AST_IRQ_FOLLOWS: assert property (
        ##1 timerIrq == ($past(irqEn)
            && ($past(ovfFlag_reg) || ($past(extFlag_reg) && !$past(isUpDown)))))
        else $error("Interrupt request does not follow the flags");

    AST_FLAGS_STICKY: assert property (
        ovfFlag_reg && !clrOvfFlag |=> ovfFlag_reg)
        else $error("Overflow flag lost without a clear");

    AST_CLKOUT_TOGGLE: assert property (
        clkoutMode && wrapEvt ##1 clkoutMode |-> clkoutPinOut != $past(clkoutPinOut))
        else $error("Clock-out pin did not toggle on overflow");

    AST_TX_ROUTE: assert property (
        tx_clk_sel && wrapEvt |=> txBaudTick)
        else $error("Transmit tick missing on selected overflow");

endmodule
`default_nettype wire

/* tb/far_side_model.sv */
// Far side of the timer: timer 1 overflow source, trigger and count pins.
// Assumes the bench commands pin levels; pins move 1 ns after the edge.
`timescale 1ns/1ns
`default_nettype none
module far_side_model #(
    parameter int T1_PERIOD = 10
) (
    // Clock and reset
    input  wire logic ref_clk,
    input  wire logic arst_n,
    // Level commands from the bench
    input  wire logic trigLevel,
    input  wire logic cntLevel,
    // Pins and serial side
    output logic      trigger_pin,
    output logic      count_pin,
    output logic      timer1Ovf
);
    int t1Cnt;

    // Pins never move on the sampling edge, so one sample sees each level
    assign #1 trigger_pin = trigLevel;
    assign #1 count_pin   = cntLevel;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            t1Cnt     <= 0;
            timer1Ovf <= 1'b0;
        end else begin
            t1Cnt     <= (t1Cnt == T1_PERIOD - 1) ? 0 : t1Cnt + 1;
            timer1Ovf <= (t1Cnt == T1_PERIOD - 1);
        end
    end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for timer2_core in every counting mode.
// Assumes far_side_model drives the pins and the timer 1 overflows.
`timescale 1ns/1ns
`default_nettype none
module tb
    import timer2_pkg::*;
;
    localparam int T1P = 10;
    logic       ref_clk, arst_n, trigLevel, cntLevel, trigger_pin, count_pin, timer1Ovf;
    logic       run_bit, cnt_sel, cap_rel_sel, ext_trig_en, down_cnt_en, clkout_en, irqEn;
    logic       clk_rate_sel, tx_clk_sel, rx_clk_sel, clrOvfFlag, clrExtFlag, timerIrq;
    logic       wrCountHi, wrCountLo, wrReloadHi, wrReloadLo, ovf_flag, ext_flag;
    logic       clkoutPinOut, clkoutPinOe, txBaudTick, rxBaudTick;
    logic [7:0] wrData, count_hi, count_lo, cap_reload_hi, cap_reload_lo;
    int         fail_count, tests_run, n;

    far_side_model #(.T1_PERIOD(T1P)) u_far (.ref_clk(ref_clk), .arst_n(arst_n),
        .trigLevel(trigLevel), .cntLevel(cntLevel), .trigger_pin(trigger_pin),
        .count_pin(count_pin), .timer1Ovf(timer1Ovf));
    timer2_core u_dut (.ref_clk(ref_clk), .arst_n(arst_n), .run_bit(run_bit),
        .cnt_sel(cnt_sel), .cap_rel_sel(cap_rel_sel), .ext_trig_en(ext_trig_en),
        .down_cnt_en(down_cnt_en), .clkout_en(clkout_en), .clk_rate_sel(clk_rate_sel),
        .tx_clk_sel(tx_clk_sel), .rx_clk_sel(rx_clk_sel), .irqEn(irqEn), .wrData(wrData),
        .wrCountHi(wrCountHi), .wrCountLo(wrCountLo), .wrReloadHi(wrReloadHi),
        .wrReloadLo(wrReloadLo), .clrOvfFlag(clrOvfFlag), .clrExtFlag(clrExtFlag),
        .count_pin(count_pin), .trigger_pin(trigger_pin), .clkoutPinOut(clkoutPinOut),
        .clkoutPinOe(clkoutPinOe), .timer1Ovf(timer1Ovf), .txBaudTick(txBaudTick),
        .rxBaudTick(rxBaudTick), .count_hi(count_hi), .count_lo(count_lo),
        .cap_reload_hi(cap_reload_hi), .cap_reload_lo(cap_reload_lo),
        .ovf_flag(ovf_flag), .ext_flag(ext_flag), .timerIrq(timerIrq));

    initial begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic cyc(input int k);
        repeat (k) @(posedge ref_clk);
    endtask

    task automatic chk16(input string nm, input logic [15:0] exp, input logic [15:0] got);
        tests_run++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic wr16(input logic toReload, input logic [15:0] v);
        @(posedge ref_clk);
        wrData <= v[15:8];
        {wrCountHi, wrReloadHi} <= {!toReload, toReload};
        @(posedge ref_clk);
        wrData <= v[7:0];
        {wrCountHi, wrReloadHi} <= 2'b00;
        {wrCountLo, wrReloadLo} <= {!toReload, toReload};
        @(posedge ref_clk);
        {wrCountLo, wrReloadLo} <= 2'b00;
    endtask

    // Stop, wipe flags, then set mode bits; software stops before touching bytes
    task automatic idle(input logic [7:0] m);
        @(posedge ref_clk);
        run_bit <= 1'b0;
        irqEn <= 1'b1;
        {clrOvfFlag, clrExtFlag} <= 2'b11;
        @(posedge ref_clk);
        {clrOvfFlag, clrExtFlag} <= 2'b00;
        {cnt_sel, cap_rel_sel, ext_trig_en, down_cnt_en} <= m[7:4];
        {clkout_en, clk_rate_sel, tx_clk_sel, rx_clk_sel} <= m[3:0];
    endtask

    task automatic go();
        @(posedge ref_clk);
        run_bit <= 1'b1;
    endtask

    task automatic trigFall();
        @(posedge ref_clk);
        trigLevel <= 1'b0;
        cyc(10);
        trigLevel <= 1'b1;
        cyc(10);
        #1;
    endtask

    // Bounded wait: 0 overflow flag, 1 tx tick, 2 rx tick, 3 clock-out edge
    task automatic waitHit(input int sel);
        logic prev;
        logic seen;
        seen = 1'b0;
        prev = clkoutPinOut;
        n = 0;
        while (!seen && n < 3000) begin
            @(posedge ref_clk);
            #1;
            n++;
            seen = sel == 0 ? ovf_flag === 1'b1 : sel == 1 ? txBaudTick === 1'b1 :
                   sel == 2 ? rxBaudTick === 1'b1 : clkoutPinOut !== prev;
            prev = clkoutPinOut;
        end
        chk16("event seen", 16'h0001, {15'h0000, seen});
    endtask

    task automatic gap(input int sel, input int exp);
        waitHit(sel);
        waitHit(sel);
        chk16("event gap", exp[15:0], n[15:0]);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic scnReloadUp();
        idle(8'h04);
        wr16(1'b1, 16'hFFF0);
        wr16(1'b0, 16'hFFFC);
        go();
        waitHit(0);
        chk16("count", 16'hFFF0, {count_hi, count_lo});
        @(posedge ref_clk);
        #1;
        chk16("timerIrq", 16'h0001, timerIrq);
        @(posedge ref_clk);
        run_bit <= 1'b0;
        irqEn <= 1'b0;
        cyc(8);
        #1;
        chk16("ovf_flag", 16'h0001, ovf_flag);
        chk16("timerIrq", 16'h0000, timerIrq);
    endtask

    task automatic scnCapture();
        idle(8'h44);
        wr16(1'b0, 16'hFFFE);
        go();
        waitHit(0);
        chk16("count", COUNT_ZERO, {count_hi, count_lo});
        idle(8'h64);
        wr16(1'b0, 16'h1234);
        trigFall();
        chk16("capture", 16'h1234, {cap_reload_hi, cap_reload_lo});
        chk16("ext_flag", 16'h0001, ext_flag);
        chk16("timerIrq", 16'h0001, timerIrq);
        idle(8'h24);
        wr16(1'b1, 16'hABCD);
        trigFall();
        chk16("count", 16'hABCD, {count_hi, count_lo});
        chk16("ext_flag", 16'h0001, ext_flag);
    endtask

    task automatic scnUpDown();
        idle(8'h14);
        trigLevel <= 1'b0;
        wr16(1'b1, 16'h0010);
        wr16(1'b0, 16'h0014);
        cyc(10);
        go();
        waitHit(0);
        chk16("count", COUNT_ONES, {count_hi, count_lo});
        chk16("ext_flag", 16'h0001, ext_flag);
        @(posedge ref_clk);
        run_bit <= 1'b0;
        clrOvfFlag <= 1'b1;
        @(posedge ref_clk);
        clrOvfFlag <= 1'b0;
        trigLevel <= 1'b1;
        cyc(3);
        #1;
        chk16("timerIrq", 16'h0000, timerIrq);
        wr16(1'b1, 16'h0100);
        wr16(1'b0, 16'hFFFD);
        cyc(10);
        go();
        waitHit(0);
        chk16("count", 16'h0100, {count_hi, count_lo});
        chk16("ext_flag", 16'h0000, ext_flag);
    endtask

    task automatic scnSources();
        idle(8'h00);
        wr16(1'b0, COUNT_ZERO);
        go();
        cyc(120);
        run_bit <= 1'b0;
        cyc(3);
        #1;
        chk16("count", 16'(120 / DIV_SLOW), {count_hi, count_lo});
        idle(8'h84);
        wr16(1'b0, COUNT_ZERO);
        go();
        repeat (3) begin
            cntLevel <= 1'b0;
            cyc(10);
            cntLevel <= 1'b1;
            cyc(10);
        end
        run_bit <= 1'b0;
        cyc(2);
        #1;
        chk16("count", 16'h0003, {count_hi, count_lo});
    endtask

    task automatic scnBaud();
        idle(8'h0A);
        wr16(1'b1, 16'hFFF0);
        wr16(1'b0, 16'hFFF0);
        go();
        gap(1, 16 * DIV_HALF);
        gap(3, 16 * DIV_HALF);
        gap(2, T1P);
        chk16("clkoutPinOe", 16'h0001, clkoutPinOe);
        chk16("ovf_flag", 16'h0000, ovf_flag);
        chk16("timerIrq", 16'h0000, timerIrq);
        // Receive select with capture select set: baud reload must still win
        idle(8'h41);
        go();
        gap(2, 16 * DIV_HALF);
        gap(1, T1P);
        chk16("ovf_flag", 16'h0000, ovf_flag);
        idle(8'h22);
        wr16(1'b0, 16'h5555);
        trigFall();
        chk16("ext_flag", 16'h0001, ext_flag);
        chk16("count", 16'h5555, {count_hi, count_lo});
    endtask

    task automatic conclude();
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        fail_count = 0;
        tests_run = 0;
        arst_n = 1'b0;
        {run_bit, cnt_sel, cap_rel_sel, ext_trig_en, down_cnt_en, clkout_en} = '0;
        {clk_rate_sel, tx_clk_sel, rx_clk_sel, clrOvfFlag, clrExtFlag} = '0;
        {wrCountHi, wrCountLo, wrReloadHi, wrReloadLo, wrData} = '0;
        irqEn = 1'b1;
        trigLevel = 1'b1;
        cntLevel = 1'b1;
        cyc(2);
        arst_n <= 1'b1;
        #1;
        chk16("count", COUNT_RST, {count_hi, count_lo});
        chk16("flags", 16'h0000, {ovf_flag, ext_flag, clkoutPinOe});
        scnReloadUp();
        scnCapture();
        scnUpDown();
        scnSources();
        scnBaud();
        conclude();
    end

    // Whole run needs under a thousand cycles; this bound only catches a hang
    initial begin
        cyc(20000);
        fail_count++;
        $display("unexpected run length: expected under %0d cycles seen more", 20000);
        conclude();
    end
endmodule
`default_nettype wire
